// [uart_baud_map.vh]
`ifndef UART_BAUD_MAP_VH
`define UART_BAUD_MAP_VH

// register indexes; byte address is four times the index
`define IDX_BAUD_RATE_CONTROL 8'h9b
`define IDX_GENERATOR_RELOAD 8'h9a
`define IDX_TIMER_TWO_CONTROL 8'hc8
`define IDX_POWER_CONTROL 8'h87
`define IDX_CLOCK_CONTROL 8'h8f
`define IDX_GENERATOR_STATUS 8'h40

// baud_rate_control fields
`define BIT_MODE_ZERO_SOURCE 0
`define BIT_GENERATOR_SPEED 1
`define BIT_RX_INTERNAL_SELECT 2
`define BIT_TX_INTERNAL_SELECT 3
`define BIT_GENERATOR_RUN 4
`define BAUD_CTRL_WIDTH 5

// timer_two_control fields
`define BIT_T2_TX_CLOCK 4
`define BIT_T2_RX_CLOCK 5

// power_control and clock control fields
`define BIT_BAUD_DOUBLING 7
`define BIT_DOUBLE_SPEED 0

// reset values
`define RST_BAUD_CTRL 5'h00
`define RST_RELOAD 8'h00
`define RST_BYTE 8'h00

// generator figures
`define GEN_WRAP 8'hff
`define PRE_DIV_BASE 5'd4
`define PRE_DIV_DOUBLED 5'd2
`define SLOW_DIV 5'd6
`define OSC_DIV 4'd12
`define PERIPH_DIV_X2 4'd6
`define OSC_PER_PERIPH 4'd2

// source codes shown in the status register
`define SRC_TIMER1 2'h0
`define SRC_TIMER2 2'h1
`define SRC_INTERNAL 2'h2

`endif

// [uart_baud_clock_select.v]
// What this block does
// - tx and rx baud sources chosen independently
// - sources set from two separate control registers
// - tx: internal if select, else timer2/timer1
// - rx: internal if select, else timer2/timer1
// - generator runs only while run bit set
// - generator overflows every 256 minus reload counts
// - speed bit zero adds divide by six
// - rate: doubling, divide four, six, 256 minus reload
// - mode zero: internal or fixed clock divide
// - reset clears control bits; upper bits unused
// - timer two tx bit4, rx bit5
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "uart_baud_map.vh"

module uart_baud_clock_select #(
  parameter ADR_WIDTH = 10
) (
  input wire clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire timer1_tick,
  input wire timer2_tick,
  output wire tx_baud_tick,
  output wire rx_baud_tick,
  output wire mode_zero_tick,
  output wire internal_baud_generator_tick
);

  // software-visible control state, then counter, tick and bus flops
  reg [`BAUD_CTRL_WIDTH-1:0] baud_rate_control_ff;
  reg [7:0] generator_reload_value_ff;
  reg timer_two_tx_clock_select_ff;
  reg timer_two_rx_clock_select_ff;
  reg baud_doubling_bit_ff;
  reg double_speed_mode_ff;
  reg [7:0] gen_count_ff;
  reg [4:0] pre_count_ff;
  reg [3:0] m0_count_ff;
  reg gen_tick_ff;
  reg tx_tick_ff;
  reg rx_tick_ff;
  reg m0_tick_ff;
  reg ack_ff;
  reg [31:0] rdata_ff;

  // next-state and decode terms, all combinational
  reg [7:0] nxt_gen_count;
  reg [4:0] nxt_pre_count;
  reg [3:0] nxt_m0_count;
  reg nxt_gen_tick;
  reg nxt_tx_tick;
  reg nxt_rx_tick;
  reg nxt_m0_tick;
  reg [31:0] nxt_rdata;
  reg [1:0] tx_source;
  reg [1:0] rx_source;
  reg [4:0] pre_limit;
  reg [3:0] m0_limit;
  reg pre_pulse;
  reg m0_pulse;

  // field views of baud_rate_control, then bus decode terms
  wire generator_run;
  wire generator_speed;
  wire tx_internal_generator_select;
  wire rx_internal_generator_select;
  wire mode_zero_source_select;
  wire [7:0] reg_index;
  wire bus_req;
  wire wr_en;

  assign generator_run = baud_rate_control_ff[`BIT_GENERATOR_RUN];
  assign generator_speed = baud_rate_control_ff[`BIT_GENERATOR_SPEED];
  assign tx_internal_generator_select = baud_rate_control_ff[`BIT_TX_INTERNAL_SELECT];
  assign rx_internal_generator_select = baud_rate_control_ff[`BIT_RX_INTERNAL_SELECT];
  assign mode_zero_source_select = baud_rate_control_ff[`BIT_MODE_ZERO_SOURCE];

  // word addressed; byte address bits 1:0 ignored
  assign reg_index = wb_adr_i[9:2];
  // one request per ack: the cycle in which ack stands is never taken again
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // only byte lane 0 carries writable register data
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign tx_baud_tick = tx_tick_ff;
  assign rx_baud_tick = rx_tick_ff;
  assign mode_zero_tick = m0_tick_ff;
  assign internal_baud_generator_tick = gen_tick_ff;

  // register writes; a write lands on the taking edge, the same edge that raises ack
  // ack is registered, so the master still holds address and data while it stands
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      baud_rate_control_ff <= `RST_BAUD_CTRL;
      generator_reload_value_ff <= `RST_RELOAD;
      timer_two_tx_clock_select_ff <= 1'b0;
      timer_two_rx_clock_select_ff <= 1'b0;
      baud_doubling_bit_ff <= 1'b0;
      double_speed_mode_ff <= 1'b0;
    end else if (wr_en) begin
      case (reg_index)
        `IDX_BAUD_RATE_CONTROL: begin
          // reserved upper bits are dropped on write
          baud_rate_control_ff <= wb_dat_i[`BAUD_CTRL_WIDTH-1:0];
        end
        `IDX_GENERATOR_RELOAD: begin
          generator_reload_value_ff <= wb_dat_i[7:0];
        end
        `IDX_TIMER_TWO_CONTROL: begin
          timer_two_tx_clock_select_ff <= wb_dat_i[`BIT_T2_TX_CLOCK];
          timer_two_rx_clock_select_ff <= wb_dat_i[`BIT_T2_RX_CLOCK];
        end
        `IDX_POWER_CONTROL: begin
          baud_doubling_bit_ff <= wb_dat_i[`BIT_BAUD_DOUBLING];
        end
        `IDX_CLOCK_CONTROL: begin
          double_speed_mode_ff <= wb_dat_i[`BIT_DOUBLE_SPEED];
        end
        default: begin
          baud_rate_control_ff <= baud_rate_control_ff;
        end
      endcase
    end
  end

  // source selection per direction
  // a timer tick is passed one cycle late, never re-timed or stretched
  always @* begin
    if (tx_internal_generator_select) begin
      tx_source = `SRC_INTERNAL;
    end else if (timer_two_tx_clock_select_ff) begin
      tx_source = `SRC_TIMER2;
    end else begin
      tx_source = `SRC_TIMER1;
    end
    if (rx_internal_generator_select) begin
      rx_source = `SRC_INTERNAL;
    end else if (timer_two_rx_clock_select_ff) begin
      rx_source = `SRC_TIMER2;
    end else begin
      rx_source = `SRC_TIMER1;
    end
  end

  // prescaler: divide four, halved by doubling, times six when slow
  // limits are re-read each cycle: a speed or doubling change mid-count can
  // stretch or cut one generator period, so stop the generator first
  always @* begin
    if (baud_doubling_bit_ff) begin
      pre_limit = `PRE_DIV_DOUBLED;
    end else begin
      pre_limit = `PRE_DIV_BASE;
    end
    if (!generator_speed) begin
      pre_limit = pre_limit * `SLOW_DIV;
    end
    pre_pulse = (pre_count_ff == pre_limit - 5'd1);
  end

  // internal generator
  // while running, a new reload value is only picked up at the next overflow
  always @* begin
    nxt_pre_count = pre_count_ff;
    nxt_gen_count = gen_count_ff;
    nxt_gen_tick = 1'b0;
    if (!generator_run) begin
      // stopped: restart cleanly from the reload value
      nxt_pre_count = 5'd0;
      nxt_gen_count = generator_reload_value_ff;
    end else begin
      if (pre_pulse) begin
        nxt_pre_count = 5'd0;
        if (gen_count_ff == `GEN_WRAP) begin
          nxt_gen_count = generator_reload_value_ff;
          nxt_gen_tick = 1'b1;
        end else begin
          nxt_gen_count = gen_count_ff + 8'd1;
        end
      end else begin
        nxt_pre_count = pre_count_ff + 5'd1;
      end
    end
  end

  // mode zero fixed clock; clk is the peripheral clock
  // no separate oscillator input, so the standard divide is folded onto clk
  always @* begin
    if (double_speed_mode_ff) begin
      m0_limit = `PERIPH_DIV_X2;
    end else begin
      // oscillator runs at twice the peripheral clock here
      m0_limit = `OSC_DIV / `OSC_PER_PERIPH;
    end
    m0_pulse = (m0_count_ff >= m0_limit - 4'd1);
    if (m0_pulse) begin
      nxt_m0_count = 4'd0;
    end else begin
      nxt_m0_count = m0_count_ff + 4'd1;
    end
  end

  // per-direction tick routing
  // every tick leaves through a flop, so the far side sees clean one-cycle pulses
  always @* begin
    case (tx_source)
      `SRC_INTERNAL: nxt_tx_tick = nxt_gen_tick;
      `SRC_TIMER2: nxt_tx_tick = timer2_tick;
      `SRC_TIMER1: nxt_tx_tick = timer1_tick;
      default: nxt_tx_tick = 1'b0;
    endcase
    case (rx_source)
      `SRC_INTERNAL: nxt_rx_tick = nxt_gen_tick;
      `SRC_TIMER2: nxt_rx_tick = timer2_tick;
      `SRC_TIMER1: nxt_rx_tick = timer1_tick;
      default: nxt_rx_tick = 1'b0;
    endcase
    if (mode_zero_source_select) begin
      nxt_m0_tick = nxt_gen_tick;
    end else begin
      nxt_m0_tick = m0_pulse;
    end
  end

  // counters and tick flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_count_ff <= 5'd0;
      gen_count_ff <= `RST_RELOAD;
      m0_count_ff <= 4'd0;
      gen_tick_ff <= 1'b0;
      tx_tick_ff <= 1'b0;
      rx_tick_ff <= 1'b0;
      m0_tick_ff <= 1'b0;
    end else begin
      pre_count_ff <= nxt_pre_count;
      gen_count_ff <= nxt_gen_count;
      m0_count_ff <= nxt_m0_count;
      gen_tick_ff <= nxt_gen_tick;
      tx_tick_ff <= nxt_tx_tick;
      rx_tick_ff <= nxt_rx_tick;
      m0_tick_ff <= nxt_m0_tick;
    end
  end

  // read mux; unmapped indexes read zero and still ack
  // the status word is a debug view of live selection and count
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (reg_index)
      `IDX_BAUD_RATE_CONTROL: begin
        nxt_rdata[`BAUD_CTRL_WIDTH-1:0] = baud_rate_control_ff;
      end
      `IDX_GENERATOR_RELOAD: begin
        nxt_rdata[7:0] = generator_reload_value_ff;
      end
      `IDX_TIMER_TWO_CONTROL: begin
        nxt_rdata[`BIT_T2_TX_CLOCK] = timer_two_tx_clock_select_ff;
        nxt_rdata[`BIT_T2_RX_CLOCK] = timer_two_rx_clock_select_ff;
      end
      `IDX_POWER_CONTROL: begin
        nxt_rdata[`BIT_BAUD_DOUBLING] = baud_doubling_bit_ff;
      end
      `IDX_CLOCK_CONTROL: begin
        nxt_rdata[`BIT_DOUBLE_SPEED] = double_speed_mode_ff;
      end
      `IDX_GENERATOR_STATUS: begin
        nxt_rdata[7:0] = gen_count_ff;
        nxt_rdata[9:8] = tx_source;
        nxt_rdata[11:10] = rx_source;
        nxt_rdata[12] = generator_run;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data is zero outside the ack cycle so a stale word never shows
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req) begin
        rdata_ff <= nxt_rdata;
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

endmodule

// [uart_baud_props_properties.sv]
`timescale 1ns/1ps
module uart_baud_props #(
  parameter ADR_WIDTH = 10
) (
  input wire clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire timer1_tick,
  input wire timer2_tick,
  input wire tx_baud_tick,
  input wire rx_baud_tick,
  input wire mode_zero_tick,
  input wire internal_baud_generator_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [4:0] ctl_ff;
  logic [7:0] rel_ff;
  logic [1:0] t2_ff;
  logic smod_ff;
  logic clean_ff;
  logic [15:0] gap_ff;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire [7:0] idx = wb_adr_i[9:2];
  wire gen = internal_baud_generator_tick;
  wire [15:0] period = (smod_ff ? 16'h2 : 16'h4) * (ctl_ff[1] ? 16'h1 : 16'h6) * (16'h100 - rel_ff);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_ff <= 5'h00;
      rel_ff <= 8'h00;
      t2_ff <= 2'h0;
      smod_ff <= 1'b0;
      clean_ff <= 1'b0;
      gap_ff <= 16'h0;
    end else begin
      if (wr && idx == 8'h9b) ctl_ff <= wb_dat_i[4:0];
      if (wr && idx == 8'h9a) rel_ff <= wb_dat_i[7:0];
      if (wr && idx == 8'hc8) t2_ff <= wb_dat_i[5:4];
      if (wr && idx == 8'h87) smod_ff <= wb_dat_i[7];
      // a write may change the period, so the gap it spans is skipped
      clean_ff <= wr ? 1'b0 : (gen ? 1'b1 : clean_ff);
      gap_ff <= gen ? 16'h1 : gap_ff + 16'h1;
    end
  end
  property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_txt; !ctl_ff[3] && (t2_ff[0] ? timer2_tick : timer1_tick) |=> tx_baud_tick; endproperty
  a_txt: assert property (p_txt) else $error("tx timer tick lost");
  property p_rxt; !ctl_ff[2] && (t2_ff[1] ? timer2_tick : timer1_tick) |=> rx_baud_tick; endproperty
  a_rxt: assert property (p_rxt) else $error("rx timer tick lost");
  property p_txi; ctl_ff[3] && $past(ctl_ff[3]) |-> tx_baud_tick == gen; endproperty
  a_txi: assert property (p_txi) else $error("tx not on generator");
  property p_rxi; ctl_ff[2] && $past(ctl_ff[2]) |-> rx_baud_tick == gen; endproperty
  a_rxi: assert property (p_rxi) else $error("rx not on generator");
  property p_stop; !ctl_ff[4] && !$past(ctl_ff[4]) |-> !gen; endproperty
  a_stop: assert property (p_stop) else $error("generator ticks while stopped");
  property p_per; gen && clean_ff |-> gap_ff == period; endproperty
  a_per: assert property (p_per) else $error("generator period wrong");
  property p_m0; mode_zero_tick && !ctl_ff[0] |=> !mode_zero_tick [*5] ##1 (mode_zero_tick || ctl_ff[0]); endproperty
  a_m0: assert property (p_m0) else $error("mode zero fixed period wrong");
  c_per: cover property (gen && clean_ff);
  c_txi: cover property (tx_baud_tick && ctl_ff[3]);
  c_m0: cover property (mode_zero_tick && ctl_ff[0]);
endmodule

// [timer_tick_model.sv]
`timescale 1ns/1ps
// coprime periods so the two timer sources can be told apart
module timer_tick_model #(
  parameter P1 = 7,
  parameter P2 = 5
) (
  input wire clk,
  input wire rstn,
  output logic timer1_tick,
  output logic timer2_tick
);
  logic [7:0] c;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c <= 8'h00;
      timer1_tick <= 1'b0;
      timer2_tick <= 1'b0;
    end else begin
      c <= c + 8'h01;
      timer1_tick <= (c % P1) == 0;
      timer2_tick <= (c % P2) == 0;
    end
  end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, t1, t2, txt, rxt, m0t, gen;
  logic [9:0] cfg [4] = '{10'h3fe, 10'h1fe, 10'h2ff, 10'h0fd};
  int n_fail = 0;
  int checks = 0;
  int n;
  uart_baud_clock_select uart_baud_clock_select_i (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .timer1_tick(t1), .timer2_tick(t2), .tx_baud_tick(txt),
    .rx_baud_tick(rxt), .mode_zero_tick(m0t), .internal_baud_generator_tick(gen));
  timer_tick_model timer_tick_model_i (.clk(clk), .rstn(rstn), .timer1_tick(t1), .timer2_tick(t2));
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    final_report;
  end
  task final_report;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n, 2);
  endtask
  // counts cycles between two ticks of the generator or the mode zero clock
  task gap(input logic m0, input int exp);
    n = 0;
    while ((m0 ? m0t : gen) !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((m0 ? m0t : gen) !== 1'b1 && n < 2000);
    chk(n, exp);
  endtask
  // tx and rx repeat the chosen timer tick one cycle late, or stay low on the idle generator
  task route(input int i);
    logic pt, pr;
    @(posedge clk);
    pt = i[0] ? t2 : t1;
    pr = i[1] ? t2 : t1;
    repeat (14) begin
      @(posedge clk);
      chk(txt, i[3] ? 1'b0 : pt);
      chk(rxt, i[2] ? 1'b0 : pr);
      pt = i[0] ? t2 : t1;
      pr = i[1] ? t2 : t1;
    end
  endtask
  task s_reset;
    bus(0, 8'h9b, 8'h00);
    chk(q, 32'h0);
    bus(0, 8'h9a, 8'h00);
    chk(q, 32'h0);
  endtask
  task s_select;
    for (int i = 0; i < 16; i++) begin
      bus(1, 8'hc8, {2'b00, i[1:0], 4'h0});
      bus(1, 8'h9b, {4'h0, i[3:2], 2'b00});
      bus(0, 8'h40, 8'h00);
      chk(q, {20'h0, i[2] ? 2'h2 : {1'b0, i[1]}, i[3] ? 2'h2 : {1'b0, i[0]}, 8'h00});
      route(i);
    end
  endtask
  task s_rate;
    for (int k = 0; k < 4; k++) begin
      bus(1, 8'h9b, 8'h0c);
      bus(1, 8'h87, {cfg[k][9], 7'h00});
      bus(1, 8'h9a, cfg[k][7:0]);
      bus(1, 8'h9b, {6'h07, cfg[k][8], 1'b0});
      gap(0, (cfg[k][9] ? 2 : 4) * (cfg[k][8] ? 1 : 6) * (256 - cfg[k][7:0]));
    end
    bus(1, 8'h9b, 8'h0c);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      n = n + (gen === 1'b1);
    end
    chk(n, 0);
    bus(0, 8'h40, 8'h00);
    chk(q, 32'h00000afd);
  endtask
  task s_mode0;
    bus(1, 8'h8f, 8'h01);
    gap(1, 6);
    bus(1, 8'h8f, 8'h00);
    gap(1, 6);
    bus(1, 8'h9b, 8'h01);
    bus(1, 8'h9a, 8'hfe);
    bus(1, 8'h87, 8'h80);
    bus(1, 8'h9b, 8'h13);
    gap(1, 4);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    s_reset;
    s_select;
    s_rate;
    s_mode0;
    final_report;
  end
endmodule
bind uart_baud_clock_select uart_baud_props #(.ADR_WIDTH(ADR_WIDTH)) uart_baud_props_i (.*);
